// ### design/pld_defines.svh
// offsets, field positions, reset values and timing counts of the link-drop and indirect-access bank
// assumes a 250 MHz system clock and 32-bit AXI4-Lite register access
`ifndef PLD_DEFINES_SVH
`define PLD_DEFINES_SVH

// register indices; byte address is four times the index
`define PLD_IDX_CTRL3 6'h0b
`define PLD_IDX_INDCMD 6'h0d
`define PLD_IDX_INDDATA 6'h0e
`define PLD_IDX_DROPSTAT 6'h0f

`define PLD_CTRL3_RST 16'h1000
`define PLD_DEVSEL_RST 5'h00
`define PLD_PTR_RST 16'h0000
`define PLD_STAT_RST 5'h00

// control_three_link_drop_and_swap fields
`define PLD_C3_POL 6
`define PLD_C3_SWAP 5
`define PLD_C3_DESCR 10
`define PLD_C3_RXERR 3
`define PLD_C3_MLT3 2
`define PLD_C3_SNR 1
`define PLD_C3_ENERGY 0

// indirect_access_command fields
`define PLD_CMD_HI 15
`define PLD_CMD_LO 14
`define PLD_DEV_HI 4
`define PLD_DEV_LO 0
`define PLD_INDCMD_RSVD 9'h000

`define PLD_DEV_VENDOR 5'h1f
`define PLD_DEV_PCS 5'h03
`define PLD_DEV_AUTONEG 5'h07

// link_drop_cause_status field, bits 8:4, order descr,rx,mlt3,snr,energy
`define PLD_ST_HIGH_PAD 7'h00
`define PLD_ST_LOW_PAD 4'h0
`define PLD_ST_DESCR 4
`define PLD_ST_RXERR 3
`define PLD_ST_MLT3 2
`define PLD_ST_SNR 1
`define PLD_ST_ENERGY 0

// trigger thresholds and window
`define PLD_RXERR_THRESH 32
`define PLD_MLT3_THRESH 20
`define PLD_SNR_THRESH 20
`define PLD_WINDOW_NS 10000
`define PLD_CLK_NS 4
`define PLD_WINDOW_CYC (`PLD_WINDOW_NS / `PLD_CLK_NS)

`define PLD_DATA_PAD 16'h0000
`define PLD_PTR_STEP 16'h0001

`endif

// ### design/pld_pkg.sv
// types shared by the link-drop and indirect-access bank
// assumes pld_defines.svh holds all numeric constants
package pld_pkg;

  typedef enum logic [1:0] {
    PLD_CMD_ADDR = 2'b00,
    PLD_CMD_DATA = 2'b01,
    PLD_CMD_POST_RW = 2'b10,
    PLD_CMD_POST_W = 2'b11
  } pld_cmd_t;

  typedef enum logic [1:0] {
    PLD_MMD_VENDOR = 2'b00,
    PLD_MMD_PCS = 2'b01,
    PLD_MMD_AUTONEG = 2'b10
  } pld_mmd_t;

  typedef enum logic [1:0] {
    PLD_RESP_OKAY = 2'b00,
    PLD_RESP_SLVERR = 2'b10
  } pld_resp_t;

endpackage

// ### design/pld_event_window.sv
// event counter over a fixed window; pulses when the count reaches a threshold
// assumes i_event is a one-cycle-per-event signal on the same clock
`timescale 1ns/1ps
`default_nettype none

module pld_event_window #(
  parameter int THRESH = 20,
  parameter int WINDOW = 2500
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // event side
  input wire logic i_enable,
  input wire logic i_event,
  output logic o_fire
);

  localparam int CW = $clog2(THRESH + 1);
  localparam int TW = $clog2(WINDOW);

  logic [TW-1:0] timer, next_timer;
  logic [CW-1:0] count, next_count;
  logic fire, next_fire;
  logic window_end;
  logic hit;

  always_comb begin
    window_end = (timer == TW'(WINDOW - 1));
    hit = i_enable && i_event && (count == CW'(THRESH - 1));
    next_timer = window_end ? '0 : TW'(timer + 1'b1);
    next_fire = hit;
    // an event on the wrap cycle opens the next window
    if (!i_enable || hit) begin
      next_count = '0;
    end else if (window_end) begin
      next_count = CW'(i_event);
    end else begin
      next_count = CW'(count + CW'(i_event));
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer <= '0;
      count <= '0;
      fire <= 1'b0;
    end else begin
      timer <= next_timer;
      count <= next_count;
      fire <= next_fire;
    end
  end

  assign o_fire = fire;

endmodule // pld_event_window

`default_nettype wire

// ### design/pld_top.sv
// link-drop control, pair swap controls and indirect extended-register access behind AXI4-Lite
// assumes trigger inputs come from datapath logic on i_clk_sys; one write and one read at a time
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "pld_defines.svh"

// Summary of operation
// - polarity swap bit set inverts polarity on transmit and receive pairs
// - pair swap bit set exchanges transmit and receive pair roles
// - port mirror output active only while both swap bits are set
// - rx error trigger drops link at 32 errors within 10 us
// - line code trigger drops link at 20 violations within 10 us
// - low snr trigger drops link at 20 threshold crossings within 10 us
// - energy trigger drops link while energy loss is reported
// - link drop is the OR of all five enabled triggers
// - the four low trigger enables reset to zero
// - command 00 targets the pointer, 01 data without increment
// - command 10 increments pointer after every data read or write
// - command 11 increments pointer after data writes only
// - device select field routes every data register access
// - select 11111 reaches the vendor register space
// - select 00011 reaches pcs, 00111 reaches auto-negotiation device
// - accesses with any other device select are ignored
// - data register shows pointer for command 00, data otherwise
// - control bit 10 enables the descrambler loss trigger
// - each firing trigger latches its own status bit, cleared on read
module pld_top #(
  parameter int ADDR_W = 8,
  parameter int MMD_DEPTH = 16,
  parameter int WINDOW_CYC = `PLD_WINDOW_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output pld_pkg::pld_resp_t o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [31:0] o_rdata,
  output pld_pkg::pld_resp_t o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // link-drop sources from the datapath
  input wire logic i_rx_err,
  input wire logic i_mlt3_viol,
  input wire logic i_low_snr,
  input wire logic i_energy_lost,
  input wire logic i_descr_loss,
  // controls to the datapath
  output logic o_pol_invert,
  output logic o_pair_swap,
  output logic o_port_mirror,
  output logic o_link_drop
);

  import pld_pkg::*;

  localparam int MW = $clog2(MMD_DEPTH);
  localparam int NDEV = 3;
  localparam int IW = ADDR_W - 2;

  // bus state
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  pld_resp_t bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  pld_resp_t rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;

  // register state
  logic [15:0] ctrl3, next_ctrl3;
  pld_cmd_t cmd, next_cmd;
  logic [4:0] devsel, next_devsel;
  logic [15:0] ptr [NDEV];
  logic [15:0] next_ptr [NDEV];
  logic [4:0] drop_stat, next_drop_stat;
  logic mirror, next_mirror;
  logic link_drop, next_link_drop;

  // indirect storage, one bank per reachable device
  logic [15:0] mmd_mem [NDEV][MMD_DEPTH];
  logic mem_we;
  logic [1:0] mem_dev;
  logic [MW-1:0] mem_idx;
  logic [15:0] mem_wd;

  // decode and trigger wires
  logic wr_fire;
  logic rd_take;
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic dev_ok;
  logic [1:0] dev;
  logic in_range;
  logic [15:0] cur_data;
  logic [15:0] rd_val;
  logic [15:0] cmd_word;
  logic rd_inc;
  logic wr_inc;
  logic [4:0] fires;
  logic fire_rx, fire_mlt3, fire_snr;

  function automatic logic [15:0] pld_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    pld_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // {valid, bank} for a device select value
  function automatic logic [2:0] pld_decode(input logic [4:0] sel);
    case (sel)
      `PLD_DEV_VENDOR: pld_decode = {1'b1, PLD_MMD_VENDOR};
      `PLD_DEV_PCS: pld_decode = {1'b1, PLD_MMD_PCS};
      `PLD_DEV_AUTONEG: pld_decode = {1'b1, PLD_MMD_AUTONEG};
      default: pld_decode = {1'b0, PLD_MMD_VENDOR};
    endcase
  endfunction

  pld_event_window #(
    .THRESH(`PLD_RXERR_THRESH),
    .WINDOW(WINDOW_CYC)
  ) u_win_rx (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(ctrl3[`PLD_C3_RXERR]),
    .i_event(i_rx_err),
    .o_fire(fire_rx)
  );

  pld_event_window #(
    .THRESH(`PLD_MLT3_THRESH),
    .WINDOW(WINDOW_CYC)
  ) u_win_mlt3 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(ctrl3[`PLD_C3_MLT3]),
    .i_event(i_mlt3_viol),
    .o_fire(fire_mlt3)
  );

  pld_event_window #(
    .THRESH(`PLD_SNR_THRESH),
    .WINDOW(WINDOW_CYC)
  ) u_win_snr (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(ctrl3[`PLD_C3_SNR]),
    .i_event(i_low_snr),
    .o_fire(fire_snr)
  );

  always_comb begin
    fires = '0;
    fires[`PLD_ST_RXERR] = fire_rx;
    fires[`PLD_ST_MLT3] = fire_mlt3;
    fires[`PLD_ST_SNR] = fire_snr;
    fires[`PLD_ST_ENERGY] = ctrl3[`PLD_C3_ENERGY] && i_energy_lost;
    fires[`PLD_ST_DESCR] = ctrl3[`PLD_C3_DESCR] && i_descr_loss;

    wr_fire = !awready && !wready && !bvalid;
    rd_take = i_arvalid && arready;
    wr_idx = aw_addr[ADDR_W-1:2];
    rd_idx = i_araddr[ADDR_W-1:2];
    {dev_ok, dev} = pld_decode(devsel);
    in_range = (ptr[dev] < 16'(MMD_DEPTH));
    cur_data = in_range ? mmd_mem[dev][ptr[dev][MW-1:0]] : `PLD_DATA_PAD;
    cmd_word = pld_merge({cmd, `PLD_INDCMD_RSVD, devsel}, w_data, w_strb);

    next_awready = awready;
    next_wready = wready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_ctrl3 = ctrl3;
    next_cmd = cmd;
    next_devsel = devsel;
    for (int d = 0; d < NDEV; d++) begin
      next_ptr[d] = ptr[d];
    end
    mem_we = 1'b0;
    mem_dev = dev;
    mem_idx = ptr[dev][MW-1:0];
    mem_wd = pld_merge(cur_data, w_data, w_strb);
    rd_val = `PLD_DATA_PAD;
    rd_inc = 1'b0;
    wr_inc = 1'b0;

    // address and data are parked until both have arrived
    if (i_awvalid && awready) begin
      next_awready = 1'b0;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && wready) begin
      next_wready = 1'b0;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end

    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = PLD_RESP_OKAY;
      if (wr_idx == IW'(`PLD_IDX_CTRL3)) begin
        next_ctrl3 = pld_merge(ctrl3, w_data, w_strb);
      end else if (wr_idx == IW'(`PLD_IDX_INDCMD)) begin
        next_cmd = pld_cmd_t'(cmd_word[`PLD_CMD_HI:`PLD_CMD_LO]);
        next_devsel = cmd_word[`PLD_DEV_HI:`PLD_DEV_LO];
      end else if (wr_idx == IW'(`PLD_IDX_INDDATA)) begin
        if (dev_ok) begin
          if (cmd == PLD_CMD_ADDR) begin
            next_ptr[dev] = pld_merge(ptr[dev], w_data, w_strb);
          end else begin
            mem_we = in_range;
            wr_inc = (cmd == PLD_CMD_POST_RW) || (cmd == PLD_CMD_POST_W);
          end
        end
      end else if (wr_idx != IW'(`PLD_IDX_DROPSTAT)) begin
        next_bresp = PLD_RESP_SLVERR;
      end
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end

    next_drop_stat = drop_stat;
    if (rd_take) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = PLD_RESP_OKAY;
      if (rd_idx == IW'(`PLD_IDX_CTRL3)) begin
        rd_val = ctrl3;
      end else if (rd_idx == IW'(`PLD_IDX_INDCMD)) begin
        rd_val = {cmd, `PLD_INDCMD_RSVD, devsel};
      end else if (rd_idx == IW'(`PLD_IDX_INDDATA)) begin
        if (dev_ok) begin
          rd_val = (cmd == PLD_CMD_ADDR) ? ptr[dev] : cur_data;
          rd_inc = (cmd == PLD_CMD_POST_RW);
        end
      end else if (rd_idx == IW'(`PLD_IDX_DROPSTAT)) begin
        rd_val = {`PLD_ST_HIGH_PAD, drop_stat, `PLD_ST_LOW_PAD};
        next_drop_stat = '0;
      end else begin
        next_rresp = PLD_RESP_SLVERR;
      end
      next_rdata = {`PLD_DATA_PAD, rd_val};
    end
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    // a trigger in the clearing read's cycle stays latched
    next_drop_stat = next_drop_stat | fires;

    // read and write may both step the same pointer in one cycle
    if (!(wr_fire && wr_idx == IW'(`PLD_IDX_INDDATA) && cmd == PLD_CMD_ADDR)) begin
      next_ptr[dev] = 16'(ptr[dev] + (rd_inc ? `PLD_PTR_STEP : `PLD_DATA_PAD)
                          + (wr_inc ? `PLD_PTR_STEP : `PLD_DATA_PAD));
    end

    next_mirror = next_ctrl3[`PLD_C3_POL] && next_ctrl3[`PLD_C3_SWAP];
    next_link_drop = |fires;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= PLD_RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= PLD_RESP_OKAY;
      rdata <= '0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      ctrl3 <= `PLD_CTRL3_RST;
      cmd <= PLD_CMD_ADDR;
      devsel <= `PLD_DEVSEL_RST;
      for (int d = 0; d < NDEV; d++) begin
        ptr[d] <= `PLD_PTR_RST;
      end
      drop_stat <= `PLD_STAT_RST;
      mirror <= 1'b0;
      link_drop <= 1'b0;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      ctrl3 <= next_ctrl3;
      cmd <= next_cmd;
      devsel <= next_devsel;
      for (int d = 0; d < NDEV; d++) begin
        ptr[d] <= next_ptr[d];
      end
      drop_stat <= next_drop_stat;
      mirror <= next_mirror;
      link_drop <= next_link_drop;
    end
  end

  // storage carries no reset; contents are undefined until written
  always_ff @(posedge i_clk_sys) begin
    if (mem_we) begin
      mmd_mem[mem_dev][mem_idx] <= mem_wd;
    end
  end

  assign o_awready = awready;
  assign o_wready = wready;
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_arready = arready;
  assign o_rvalid = rvalid;
  assign o_rresp = rresp;
  assign o_rdata = rdata;
  assign o_pol_invert = ctrl3[`PLD_C3_POL];
  assign o_pair_swap = ctrl3[`PLD_C3_SWAP];
  assign o_port_mirror = mirror;
  assign o_link_drop = link_drop;

endmodule // pld_top

`default_nettype wire

// ### tb/pld_checker.sv
// concurrent checks on the ports of pld_top, bound at the foot of this file
// assumes aw and w arrive together and ctrl3 writes use byte lanes 0 and 1
`timescale 1ns/1ps
`default_nettype none
`include "pld_defines.svh"

module pld_checker #(
  parameter int ADDR_W = 8,
  parameter int MMD_DEPTH = 16,
  parameter int WINDOW_CYC = 2500
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register bus
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire pld_pkg::pld_resp_t o_rresp,
  // link-drop sources and controls
  input wire logic i_energy_lost,
  input wire logic i_descr_loss,
  input wire logic o_pol_invert,
  input wire logic o_pair_swap,
  input wire logic o_port_mirror,
  input wire logic o_link_drop
);
  import pld_pkg::*;
  logic wr_take;
  logic c3_take;
  logic drop_src;
  logic [4:0] en;
  logic [4:0] sel;
  logic [2:0] quiet;
  assign wr_take = i_awvalid && o_awready && i_wvalid && o_wready;
  assign c3_take = wr_take && (i_awaddr == {`PLD_IDX_CTRL3, 2'b00});
  assign drop_src = (i_energy_lost && en[0]) || (i_descr_loss && en[4]);
  // quiet counts cycles, up to 7, since the last control register write; the design lags this copy by one edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en <= 5'h00;
      sel <= 5'h00;
      quiet <= 3'd7;
    end else begin
      quiet <= quiet + {2'b00, quiet != 3'd7};
      if (c3_take) begin
        en <= {i_wdata[`PLD_C3_DESCR], i_wdata[3:0]};
        quiet <= 3'd0;
      end
      if (wr_take && (i_awaddr == {`PLD_IDX_INDCMD, 2'b00})) begin
        sel <= i_wdata[4:0];
      end
    end
  end

  property p_pol;
    @(posedge i_clk_sys) disable iff (!i_rst_n) c3_take |-> ##2 (o_pol_invert == $past(i_wdata[`PLD_C3_POL], 2));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity output does not follow control write");
  property p_swap;
    @(posedge i_clk_sys) disable iff (!i_rst_n) c3_take |-> ##2 (o_pair_swap == $past(i_wdata[`PLD_C3_SWAP], 2));
  endproperty
  a_swap: assert property (p_swap) else $error("pair swap output does not follow control write");
  property p_mirror;
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_port_mirror == (o_pol_invert && o_pair_swap);
  endproperty
  a_mirror: assert property (p_mirror) else $error("port mirror not the and of both swaps");
  property p_energy;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (i_energy_lost && en[0] && quiet == 3'd7) |=> o_link_drop;
  endproperty
  a_energy: assert property (p_energy) else $error("energy loss did not drop link");
  property p_descr;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (i_descr_loss && en[4] && quiet == 3'd7) |=> o_link_drop;
  endproperty
  a_descr: assert property (p_descr) else $error("descrambler loss did not drop link");
  property p_level_or;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (en[3:1] == 3'b000 && quiet == 3'd7) |-> (o_link_drop == $past(drop_src));
  endproperty
  a_level_or: assert property (p_level_or) else $error("link drop differs from enabled level sources");
  property p_no_enable;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (en == 5'h00 && quiet == 3'd7) |-> !o_link_drop;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("link drop with no trigger enabled");
  property p_bad_sel;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_arvalid && o_arready && i_araddr == {`PLD_IDX_INDDATA, 2'b00}
       && !(sel inside {`PLD_DEV_VENDOR, `PLD_DEV_PCS, `PLD_DEV_AUTONEG}))
      |=> (o_rdata == 32'h0000_0000 && o_rresp == PLD_RESP_OKAY);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("unsupported device select returned data");
endmodule // pld_checker

bind pld_top pld_checker #(.ADDR_W(ADDR_W), .MMD_DEPTH(MMD_DEPTH), .WINDOW_CYC(WINDOW_CYC)) pld_checker_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wdata(i_wdata), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_energy_lost(i_energy_lost),
  .i_descr_loss(i_descr_loss), .o_pol_invert(o_pol_invert), .o_pair_swap(o_pair_swap),
  .o_port_mirror(o_port_mirror), .o_link_drop(o_link_drop));
`default_nettype wire

// ### tb/pld_axi_master.sv
// management-side bus master: one write or one read at a time over axi4-lite
// assumes slave outputs are registers, so they are read before the edge's updates land
`timescale 1ns/1ps
`default_nettype none

module pld_axi_master (
  // clock
  input wire logic i_clk_sys,
  // write channels
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire pld_pkg::pld_resp_t i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  // read channels
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire pld_pkg::pld_resp_t i_rresp,
  input wire logic i_rvalid,
  output logic o_rready
);
  import pld_pkg::*;
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready} = '0;
    o_wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output pld_resp_t r);
    logic aw_p;
    logic w_p;
    @(posedge i_clk_sys);
    o_awaddr <= a;
    o_wdata <= d;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge i_clk_sys);
      if (aw_p && i_awready) begin
        aw_p = 1'b0;
        o_awvalid <= 1'b0;
      end
      if (w_p && i_wready) begin
        w_p = 1'b0;
        o_wvalid <= 1'b0;
      end
    end
    while (i_bvalid !== 1'b1) @(posedge i_clk_sys);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output pld_resp_t r);
    @(posedge i_clk_sys);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    @(posedge i_clk_sys);
    while (i_arready !== 1'b1) @(posedge i_clk_sys);
    o_arvalid <= 1'b0;
    while (i_rvalid !== 1'b1) @(posedge i_clk_sys);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule // pld_axi_master
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for pld_top against an array and associative-array model of the register bank
// assumes a short trigger window; sources drive 0 energy,1 snr,2 mlt3,3 rx,4 descr
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pld_pkg::*;
  localparam int WIN = 50;
  logic i_clk_sys, i_rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic pol, swap, mirror, drop, seen, known;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [4:0] src;
  logic [4:0] devs [4] = '{5'h1f, 5'h03, 5'h07, 5'h05};
  pld_resp_t bresp, rresp;
  int err_count, samples_checked, seed, i, s, k, c, dv, key, rdx;
  int ptr [32];
  int mem [int];

  pld_axi_master pld_axi_master_inst (.i_clk_sys(i_clk_sys), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
    .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
  pld_top #(.WINDOW_CYC(WIN)) pld_top_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_awaddr(awaddr),
    .i_awprot(3'b000), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arprot(3'b000),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_rx_err(src[3]), .i_mlt3_viol(src[2]), .i_low_snr(src[1]), .i_energy_lost(src[0]), .i_descr_loss(src[4]),
    .o_pol_invert(pol), .o_pair_swap(swap), .o_port_mirror(mirror), .o_link_drop(drop));

  task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input pld_resp_t er);
    pld_resp_t r;
    pld_axi_master_inst.wr(a, v, r);
    check("bresp", 32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input pld_resp_t er, input logic chk);
    logic [31:0] v;
    pld_resp_t r;
    pld_axi_master_inst.rd(a, v, r);
    check("rresp", 32'(r), 32'(er));
    if (chk) check("rdata", v, ev);
  endtask
  // drives one source with a pulse every per cycles and notes any link drop, tail included
  task automatic run(input int sx, input int per, input int n, output logic sn);
    sn = 1'b0;
    for (int j = 0; j < n; j++) begin
      @(posedge i_clk_sys);
      sn = sn | (drop === 1'b1);
      src[sx] <= (j % per == 0);
    end
    @(posedge i_clk_sys);
    src <= 5'h00;
    repeat (4) @(posedge i_clk_sys) sn = sn | (drop === 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #80000;
    err_count++;
    results();
  end
  initial begin
    seed = 32'hd1b2;
    err_count = 0;
    samples_checked = 0;
    src = 5'h00;
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(8'h2c, 32'h0000_1000, PLD_RESP_OKAY, 1'b1);
    rd(8'h34, 32'h0, PLD_RESP_OKAY, 1'b1);
    rd(8'h3c, 32'h0, PLD_RESP_OKAY, 1'b1);
    rd(8'h40, 32'h0, PLD_RESP_SLVERR, 1'b1);
    wr(8'h44, 32'hffff, PLD_RESP_SLVERR);
    for (s = 0; s < 5; s++) begin
      run(s, 1, 110, seen);
      check("drop disabled", seen, 0);
    end
    $display("test reset done");
    // mirror only when software sets both swap bits
    for (k = 0; k < 4; k++) begin
      d = ($random(seed) & 32'hf390) | (k << 5);
      wr(8'h2c, d, PLD_RESP_OKAY);
      check("pol", pol, k[1]);
      check("swap", swap, k[0]);
      check("mirror", mirror, k == 3);
      rd(8'h2c, d, PLD_RESP_OKAY, 1'b1);
    end
    $display("test swap done");
    wr(8'h2c, 32'h140f, PLD_RESP_OKAY);
    for (s = 0; s < 5; s++) begin
      if (s > 0 && s < 4) begin
        // sparse pulses stay below the threshold inside any window
        run(s, (s == 3) ? 2 : 3, 200, seen);
        check("drop sparse", seen, 0);
      end
      run(s, 1, 110, seen);
      check("drop", seen, 1);
      repeat (4) @(posedge i_clk_sys);
      check("drop released", drop, 0);
      rd(8'h3c, 32'h1 << (s + 4), PLD_RESP_OKAY, 1'b1);
      rd(8'h3c, 32'h0, PLD_RESP_OKAY, 1'b1);
    end
    // level sources alone, counted triggers off: drop follows the pulses
    wr(8'h2c, 32'h1401, PLD_RESP_OKAY);
    run(4, 3, 60, seen);
    check("drop level", seen, 1);
    rd(8'h3c, 32'h100, PLD_RESP_OKAY, 1'b1);
    $display("test link drop done");
    // random indirect traffic; unsupported select 05 is sent on purpose
    for (i = 0; i < 80; i++) begin
      c = $unsigned($random(seed)) % 4;
      dv = devs[$unsigned($random(seed)) % 4];
      d = $random(seed);
      wr(8'h34, {16'h0, c[1:0], d[8:0], dv[4:0]}, PLD_RESP_OKAY);
      rd(8'h34, {16'h0, c[1:0], 9'h000, dv[4:0]}, PLD_RESP_OKAY, 1'b1);
      known = dv inside {5'h1f, 5'h03, 5'h07};
      key = dv * 65536 + ptr[dv];
      d = (c == 0) ? d % 18 : d & 32'hffff;
      if ($random(seed) & 1) begin
        wr(8'h38, d, PLD_RESP_OKAY);
        if (known && c == 0) ptr[dv] = d;
        else if (known) begin
          if (ptr[dv] < 16) mem[key] = d;
          if (c >= 2) ptr[dv] = (ptr[dv] + 1) % 65536;
        end
      end else begin
        rdx = !known ? 0 : (c == 0) ? ptr[dv] : (ptr[dv] >= 16) ? 0 : mem.exists(key) ? mem[key] : -1;
        rd(8'h38, rdx, PLD_RESP_OKAY, rdx >= 0);
        if (known && c == 2) ptr[dv] = (ptr[dv] + 1) % 65536;
      end
    end
    $display("test indirect done");
    results();
  end
endmodule // testbench
`default_nettype wire
